//--- common/lcs_consts.svh
// Offsets, field positions, reset values and timing counts of the laser control port
`ifndef LCS_CONSTS_SVH
`define LCS_CONSTS_SVH

`define LCS_OFF_CTRL 5'h00
`define LCS_OFF_STATUS 5'h04
`define LCS_OFF_TEMP 5'h08
`define LCS_OFF_FLTLATCH 5'h0c

`define LCS_CTRL_INHIBIT 0
`define LCS_CTRL_RST 1'h0

`define LCS_ST_PERMIT 0
`define LCS_ST_GATE 1
`define LCS_ST_RFON 2
`define LCS_ST_HEALTH 3
`define LCS_ST_THERMAL 4
`define LCS_ST_SUPPLY 5
`define LCS_ST_TFAULT 6
`define LCS_ST_REFLECT 7

`define LCS_TEMP_VAL_LSB 0
`define LCS_TEMP_DUTY_LSB 8

`define LCS_FLT_REFLECT 0
`define LCS_FLT_TEMP 1
`define LCS_FLT_SUPPLY 2
`define LCS_FLT_WARN 3
`define LCS_FLT_RST 4'h0

`define LCS_TEMP_WARN_C 8'h3c
`define LCS_TEMP_FAULT_C 8'h49
`define LCS_TEMP_SAT_C 8'h64
`define LCS_DUTY_MIN 7'h00
`define LCS_DUTY_MAX 7'h64

`define LCS_CLK_NS 25
`define LCS_PWM_TICK_NS 1000
`define LCS_PWM_TICK_CYC ((`LCS_PWM_TICK_NS + `LCS_CLK_NS - 1) / `LCS_CLK_NS)
`define LCS_PWM_STEPS 100

`define LCS_RESP_OKAY 2'h0
`define LCS_RESP_SLVERR 2'h2

`endif

//--- common/lcs_pkg.sv
// Types shared by the laser control port
package lcs_pkg;
    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } lcs_wr_state_type;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_DATA = 2'b10
    } lcs_rd_state_type;
endpackage : lcs_pkg

//--- core/lcs_laser_port.sv
// Laser control and status port: pin logic, thermal readout and AXI4-Lite registers
// How it works
// - RF excitation follows the gate input while the permit input is high and the software inhibit bit is clear.
// - Host raises permit first; the gate input is ignored while permit is low.
// - Health high only without reflected-power, temperature or supply fault.
// - Thermal flag high below the warning temperature, low at or above it.
// - Temperature fault at the fault temperature drops the health output.
// - Supply flag high only while supply sits strictly between both limits.
// - Readout duty cycle in percent equals internal temperature in Celsius.
// - Readout saturates at 0% for zero or below, 100% at one hundred or above.
`timescale 1ns/100ps
`include "lcs_consts.svh"

module lcs_laser_port (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic permitIn,
    input wire logic rfGateIn,
    input wire logic reflectedPowerFault,
    input wire logic [7:0] tempCelsius,
    input wire logic supplyAboveLow,
    input wire logic supplyBelowHigh,
    output logic rfOn,
    output logic healthOk,
    output logic thermalOk,
    output logic supplyOk,
    output logic tempPwm,
    input wire logic [4:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [4:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    logic inhibit_r, inhibit_nxt;
    logic rfOn_r, rfOn_nxt;
    logic health_r, health_nxt;
    logic thermal_r, thermal_nxt;
    logic supply_r, supply_nxt;
    logic tempFaultNow;
    logic tempWarnNow;
    logic supplyGood;
    logic healthNow;
    logic [6:0] dutyReq;
    logic [6:0] dutyCur;
    logic [3:0] flt_r, flt_nxt;
    logic [3:0] fltSet;
    logic [3:0] fltClr;
    lcs_pkg::lcs_wr_state_type wrState_r, wrState_nxt;
    lcs_pkg::lcs_rd_state_type rdState_r, rdState_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic wrTake;
    logic rdTake;

    // Pin status logic; outputs registered so they never glitch
    always_comb begin
        tempFaultNow = $signed(tempCelsius) >= $signed(`LCS_TEMP_FAULT_C);
        tempWarnNow = $signed(tempCelsius) >= $signed(`LCS_TEMP_WARN_C);
        supplyGood = supplyAboveLow && supplyBelowHigh;
        healthNow = !reflectedPowerFault && !tempFaultNow && supplyGood;
        // Software inhibit can only remove RF, never grant it without permit
        rfOn_nxt = permitIn && rfGateIn && !inhibit_r;
        health_nxt = healthNow;
        thermal_nxt = !tempWarnNow;
        supply_nxt = supplyGood;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rfOn_r <= 1'b0;
            health_r <= 1'b0;
            thermal_r <= 1'b0;
            supply_r <= 1'b0;
        end else begin
            rfOn_r <= rfOn_nxt;
            health_r <= health_nxt;
            thermal_r <= thermal_nxt;
            supply_r <= supply_nxt;
        end
    end

    assign rfOn = rfOn_r;
    assign healthOk = health_r;
    assign thermalOk = thermal_r;
    assign supplyOk = supply_r;

    // Duty request with saturation at both ends
    always_comb begin
        if (tempCelsius[7] || tempCelsius == 8'h00) begin
            dutyReq = `LCS_DUTY_MIN;
        end else if ($signed(tempCelsius) >= $signed(`LCS_TEMP_SAT_C)) begin
            dutyReq = `LCS_DUTY_MAX;
        end else begin
            dutyReq = tempCelsius[6:0];
        end
    end

    lcs_temp_pwm uPwm (
        .mclk(mclk),
        .rst_n(rst_n),
        .dutyReq(dutyReq),
        .pwmOut(tempPwm),
        .dutyCur(dutyCur)
    );

    // Sticky fault record; a new fault wins over a clear in the same cycle
    always_comb begin
        fltSet[`LCS_FLT_REFLECT] = reflectedPowerFault;
        fltSet[`LCS_FLT_TEMP] = tempFaultNow;
        fltSet[`LCS_FLT_SUPPLY] = !supplyGood;
        fltSet[`LCS_FLT_WARN] = tempWarnNow;
        flt_nxt = (flt_r & ~fltClr) | fltSet;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flt_r <= `LCS_FLT_RST;
        end else begin
            flt_r <= flt_nxt;
        end
    end

    // Write channel: address and data are taken together
    assign wrTake = (wrState_r == lcs_pkg::WR_IDLE) && awvalid && wvalid;
    assign awready = wrTake;
    assign wready = wrTake;
    assign bvalid = (wrState_r == lcs_pkg::WR_RESP);
    assign bresp = bresp_r;

    always_comb begin
        wrState_nxt = wrState_r;
        bresp_nxt = bresp_r;
        inhibit_nxt = inhibit_r;
        fltClr = 4'h0;
        unique case (wrState_r)
            lcs_pkg::WR_IDLE: begin
                if (wrTake) begin
                    wrState_nxt = lcs_pkg::WR_RESP;
                    bresp_nxt = awaddr[4] ? `LCS_RESP_SLVERR : `LCS_RESP_OKAY;
                    if (wstrb[0] && {awaddr[4:2], 2'b00} == `LCS_OFF_CTRL) begin
                        inhibit_nxt = wdata[`LCS_CTRL_INHIBIT];
                    end
                    if (wstrb[0] && {awaddr[4:2], 2'b00} == `LCS_OFF_FLTLATCH) begin
                        fltClr = wdata[3:0];
                    end
                end
            end
            lcs_pkg::WR_RESP: begin
                if (bready) begin
                    wrState_nxt = lcs_pkg::WR_IDLE;
                end
            end
            default: begin
                wrState_nxt = lcs_pkg::WR_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wrState_r <= lcs_pkg::WR_IDLE;
            bresp_r <= `LCS_RESP_OKAY;
            inhibit_r <= `LCS_CTRL_RST;
        end else begin
            wrState_r <= wrState_nxt;
            bresp_r <= bresp_nxt;
            inhibit_r <= inhibit_nxt;
        end
    end

    // Read channel: data captured at the address handshake
    assign rdTake = (rdState_r == lcs_pkg::RD_IDLE) && arvalid;
    assign arready = (rdState_r == lcs_pkg::RD_IDLE);
    assign rvalid = (rdState_r == lcs_pkg::RD_DATA);
    assign rdata = rdata_r;
    assign rresp = rresp_r;

    always_comb begin
        rdState_nxt = rdState_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        unique case (rdState_r)
            lcs_pkg::RD_IDLE: begin
                if (rdTake) begin
                    rdState_nxt = lcs_pkg::RD_DATA;
                    rresp_nxt = araddr[4] ? `LCS_RESP_SLVERR : `LCS_RESP_OKAY;
                    rdata_nxt = 32'h0000_0000;
                    case ({araddr[4:2], 2'b00})
                        `LCS_OFF_CTRL: begin
                            rdata_nxt[`LCS_CTRL_INHIBIT] = inhibit_r;
                        end
                        `LCS_OFF_STATUS: begin
                            rdata_nxt[`LCS_ST_PERMIT] = permitIn;
                            rdata_nxt[`LCS_ST_GATE] = rfGateIn;
                            rdata_nxt[`LCS_ST_RFON] = rfOn_r;
                            rdata_nxt[`LCS_ST_HEALTH] = health_r;
                            rdata_nxt[`LCS_ST_THERMAL] = thermal_r;
                            rdata_nxt[`LCS_ST_SUPPLY] = supply_r;
                            rdata_nxt[`LCS_ST_TFAULT] = tempFaultNow;
                            rdata_nxt[`LCS_ST_REFLECT] = reflectedPowerFault;
                        end
                        `LCS_OFF_TEMP: begin
                            rdata_nxt[`LCS_TEMP_VAL_LSB +: 8] = tempCelsius;
                            rdata_nxt[`LCS_TEMP_DUTY_LSB +: 7] = dutyCur;
                        end
                        `LCS_OFF_FLTLATCH: begin
                            rdata_nxt[3:0] = flt_r;
                        end
                    endcase
                end
            end
            lcs_pkg::RD_DATA: begin
                if (rready) begin
                    rdState_nxt = lcs_pkg::RD_IDLE;
                end
            end
            default: begin
                rdState_nxt = lcs_pkg::RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdState_r <= lcs_pkg::RD_IDLE;
            rdata_r <= 32'h0000_0000;
            rresp_r <= `LCS_RESP_OKAY;
        end else begin
            rdState_r <= rdState_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    sequence s_gate_allowed;
        permitIn && rfGateIn && !inhibit_r;
    endsequence

    sequence s_wr_take;
        awvalid && awready && wvalid && wready;
    endsequence

    sequence s_b_answer;
        bvalid && !awready;
    endsequence

    property p_rf_on;
        s_gate_allowed |=> rfOn;
    endproperty
    a_rf_on: assert property (p_rf_on) else $error("RF not on with gate and permit");

    property p_rf_off;
        !rfGateIn |=> !rfOn;
    endproperty
    a_rf_off: assert property (p_rf_off) else $error("RF on with gate low");

    property p_permit;
        !permitIn ##1 !permitIn |-> !rfOn;
    endproperty
    a_permit: assert property (p_permit) else $error("gate acted without permit");

    property p_health_fault;
        (reflectedPowerFault || !supplyAboveLow || !supplyBelowHigh) |=> !healthOk;
    endproperty
    a_health_fault: assert property (p_health_fault) else $error("health high during fault");

    property p_health_good;
        (!reflectedPowerFault && supplyAboveLow && supplyBelowHigh
            && $signed(tempCelsius) < $signed(`LCS_TEMP_FAULT_C)) |=> healthOk;
    endproperty
    a_health_good: assert property (p_health_good) else $error("health low without fault");

    property p_thermal;
        $signed(tempCelsius) < $signed(`LCS_TEMP_WARN_C) |=> thermalOk;
    endproperty
    a_thermal: assert property (p_thermal) else $error("thermal flag low below warning");

    property p_temp_fault;
        $signed(tempCelsius) >= $signed(`LCS_TEMP_FAULT_C) |=> !healthOk && !thermalOk;
    endproperty
    a_temp_fault: assert property (p_temp_fault) else $error("temperature fault not shown");

    property p_supply;
        supplyAboveLow && supplyBelowHigh |=> supplyOk;
    endproperty
    a_supply: assert property (p_supply) else $error("supply flag low inside window");

    property p_supply_bad;
        !(supplyAboveLow && supplyBelowHigh) |=> !supplyOk;
    endproperty
    a_supply_bad: assert property (p_supply_bad) else $error("supply flag high outside window");

    property p_duty_mid;
        !tempCelsius[7] && tempCelsius < `LCS_TEMP_SAT_C |-> dutyReq == tempCelsius[6:0];
    endproperty
    a_duty_mid: assert property (p_duty_mid) else $error("duty does not equal temperature");

    property p_duty_low;
        tempCelsius[7] |-> dutyReq == `LCS_DUTY_MIN;
    endproperty
    a_duty_low: assert property (p_duty_low) else $error("negative temperature not at zero duty");

    property p_duty_high;
        !tempCelsius[7] && tempCelsius >= `LCS_TEMP_SAT_C |-> dutyReq == `LCS_DUTY_MAX;
    endproperty
    a_duty_high: assert property (p_duty_high) else $error("hot temperature not at full duty");

    property p_wr_answer;
        s_wr_take |=> s_b_answer;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write not answered next cycle");

    property p_flt_set_wins;
        reflectedPowerFault |=> flt_r[`LCS_FLT_REFLECT];
    endproperty
    a_flt_set_wins: assert property (p_flt_set_wins) else $error("fault record lost a set");
endmodule : lcs_laser_port

//--- core/lcs_temp_pwm.sv
// Fixed-period PWM generator for the temperature readout
`timescale 1ns/100ps
`include "lcs_consts.svh"

module lcs_temp_pwm (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [6:0] dutyReq,
    output logic pwmOut,
    output logic [6:0] dutyCur
);
    logic [5:0] tickCnt_r, tickCnt_nxt;
    logic [6:0] step_r, step_nxt;
    logic [6:0] duty_r, duty_nxt;
    logic pwm_r, pwm_nxt;
    logic tick;
    logic wrap;

    always_comb begin
        tick = (tickCnt_r == 6'(`LCS_PWM_TICK_CYC - 1));
        wrap = tick && (step_r == 7'(`LCS_PWM_STEPS - 1));
        tickCnt_nxt = tick ? 6'h00 : tickCnt_r + 6'h01;
        step_nxt = step_r;
        duty_nxt = duty_r;
        if (tick) begin
            step_nxt = wrap ? 7'h00 : step_r + 7'h01;
        end
        // Late duty change would split a period a host is measuring
        if (wrap) begin
            duty_nxt = dutyReq;
        end
        pwm_nxt = (step_nxt < duty_nxt);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tickCnt_r <= 6'h00;
            step_r <= 7'h00;
            duty_r <= `LCS_DUTY_MIN;
            pwm_r <= 1'b0;
        end else begin
            tickCnt_r <= tickCnt_nxt;
            step_r <= step_nxt;
            duty_r <= duty_nxt;
            pwm_r <= pwm_nxt;
        end
    end

    assign pwmOut = pwm_r;
    assign dutyCur = duty_r;

    // High steps seen in the running period, so the check needs no long history
    logic [7:0] hiSteps_r, hiSteps_nxt;
    logic [7:0] hiNow;
    always_comb begin
        hiNow = hiSteps_r + {7'h00, pwm_r};
        hiSteps_nxt = hiSteps_r;
        if (wrap) begin
            hiSteps_nxt = 8'h00;
        end else if (tick) begin
            hiSteps_nxt = hiNow;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hiSteps_r <= 8'h00;
        end else begin
            hiSteps_r <= hiSteps_nxt;
        end
    end

    property p_duty_hold;
        @(posedge mclk) disable iff (!rst_n) !wrap |=> $stable(duty_r);
    endproperty
    a_duty_hold: assert property (p_duty_hold) else $error("duty changed inside a period");

    property p_duty_take;
        @(posedge mclk) disable iff (!rst_n) wrap |=> duty_r == $past(dutyReq);
    endproperty
    a_duty_take: assert property (p_duty_take) else $error("duty not taken at period end");

    property p_duty_count;
        @(posedge mclk) disable iff (!rst_n) wrap |-> hiNow == {1'b0, duty_r};
    endproperty
    a_duty_count: assert property (p_duty_count) else $error("high steps differ from duty");

    property p_full_high;
        @(posedge mclk) disable iff (!rst_n) duty_r == `LCS_DUTY_MAX |-> pwmOut;
    endproperty
    a_full_high: assert property (p_full_high) else $error("full duty not held high");
endmodule : lcs_temp_pwm

//--- tb/lcs_host_model.sv
// Host controller model driving the permit and RF gate lines
`timescale 1ns/100ps

module lcs_host_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic enableReq,
    input wire logic fireReq,
    input wire logic skipOrder,
    output logic permitIn,
    output logic rfGateIn
);
    logic permit_r;
    logic gate_r;
    logic permit_nxt;
    logic gate_nxt;

    always_comb begin
        permit_nxt = enableReq;
        // Gate only once permit is already up, unless told to misbehave
        gate_nxt = fireReq & (permit_r | skipOrder);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            permit_r <= 1'b0;
            gate_r <= 1'b0;
        end else begin
            permit_r <= permit_nxt;
            gate_r <= gate_nxt;
        end
    end

    assign permitIn = permit_r;
    assign rfGateIn = gate_r;
endmodule : lcs_host_model

//--- tb/tb_top.sv
// Self-checking bench for the laser control port
`timescale 1ns/100ps
`include "lcs_consts.svh"

module tb_top;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic enableReq = 1'b0, fireReq = 1'b0, skipOrder = 1'b0;
    logic permitIn, rfGateIn, rfOn, healthOk, thermalOk, supplyOk, tempPwm;
    logic reflectedPowerFault = 1'b0, supplyAboveLow = 1'b1, supplyBelowHigh = 1'b1;
    logic [7:0] tempCelsius = 8'h19;
    logic [4:0] awaddr = 5'h00, araddr = 5'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int fails = 0;
    int checks = 0;

    always #12.5 mclk = ~mclk;

    lcs_host_model lcs_host_model_inst (.mclk(mclk), .rst_n(rst_n), .enableReq(enableReq), .fireReq(fireReq),
        .skipOrder(skipOrder), .permitIn(permitIn), .rfGateIn(rfGateIn));

    lcs_laser_port lcs_laser_port_inst (.mclk(mclk), .rst_n(rst_n), .permitIn(permitIn), .rfGateIn(rfGateIn),
        .reflectedPowerFault(reflectedPowerFault), .tempCelsius(tempCelsius), .supplyAboveLow(supplyAboveLow),
        .supplyBelowHigh(supplyBelowHigh), .rfOn(rfOn), .healthOk(healthOk), .thermalOk(thermalOk),
        .supplyOk(supplyOk), .tempPwm(tempPwm), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));

    task automatic end_sim;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic chk_pin(input string name, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask : chk_pin

    task automatic chk_num(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_num

    task automatic timeout(input string name);
        fails++;
        $display("[ERR] %s expected handshake seen timeout", name);
        end_sim();
    endtask : timeout

    // Pin outputs are one cycle behind, the host model adds one more
    task automatic settle;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
    endtask : settle

    task automatic axi_wr(input logic [4:0] addr, input logic [31:0] data, output logic [1:0] resp);
        int n;
        bit awDone;
        bit wDone;
        n = 0;
        awDone = 0;
        wDone = 0;
        @(posedge mclk);
        awaddr <= addr;
        wdata <= data;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(awDone && wDone)) begin
            @(posedge mclk);
            if (++n > 50) timeout("awready");
            if (!awDone && awready === 1'b1) begin
                awDone = 1;
                awvalid <= 1'b0;
            end
            if (!wDone && wready === 1'b1) begin
                wDone = 1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) begin
            @(posedge mclk);
            if (++n > 100) timeout("bvalid");
        end
        resp = bresp;
        bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [4:0] addr, output logic [31:0] data, output logic [1:0] resp);
        int n;
        n = 0;
        @(posedge mclk);
        araddr <= addr;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (++n > 50) timeout("arready");
        end while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) begin
            @(posedge mclk);
            if (++n > 100) timeout("rvalid");
        end
        data = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : axi_rd

    task automatic t_regs;
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(`LCS_OFF_CTRL, d, r);
        chk_num("ctrl reset", 32'h0, d);
        chk_num("ctrl resp", {30'h0, `LCS_RESP_OKAY}, {30'h0, r});
        // No byte strobe: the write is answered but must not land
        wstrb <= 4'h0;
        axi_wr(`LCS_OFF_CTRL, 32'h1, r);
        wstrb <= 4'hf;
        chk_num("no strobe bresp", {30'h0, `LCS_RESP_OKAY}, {30'h0, r});
        axi_rd(`LCS_OFF_CTRL, d, r);
        chk_num("ctrl no strobe", 32'h0, d);
        axi_rd(5'h10, d, r);
        chk_num("unmapped rdata", 32'h0, d);
        chk_num("unmapped rresp", {30'h0, `LCS_RESP_SLVERR}, {30'h0, r});
        axi_wr(5'h1c, 32'h1, r);
        chk_num("unmapped bresp", {30'h0, `LCS_RESP_SLVERR}, {30'h0, r});
        $display("test regs done");
    endtask : t_regs

    task automatic t_rf;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge mclk);
        enableReq <= 1'b1;
        fireReq <= 1'b1;
        settle();
        chk_pin("rfOn gate high", 1'b1, rfOn);
        @(posedge mclk);
        fireReq <= 1'b0;
        settle();
        chk_pin("rfOn gate low", 1'b0, rfOn);
        @(posedge mclk);
        enableReq <= 1'b0;
        skipOrder <= 1'b1;
        fireReq <= 1'b1;
        settle();
        chk_pin("rfOn no permit", 1'b0, rfOn);
        axi_wr(`LCS_OFF_CTRL, 32'h1, r);
        enableReq <= 1'b1;
        settle();
        chk_pin("rfOn inhibited", 1'b0, rfOn);
        axi_wr(`LCS_OFF_CTRL, 32'h0, r);
        settle();
        chk_pin("rfOn released", 1'b1, rfOn);
        // Permit, gate, RF on, health, thermal and supply all up; no fault bits
        axi_rd(`LCS_OFF_STATUS, d, r);
        chk_num("status all good", 32'h3f, d);
        @(posedge mclk);
        enableReq <= 1'b0;
        fireReq <= 1'b0;
        skipOrder <= 1'b0;
        $display("test rf done");
    endtask : t_rf

    task automatic t_flags;
        logic [7:0] tv [10] = '{8'h19, 8'hf6, 8'h3b, 8'h3c, 8'h48, 8'h49, 8'h19, 8'h19, 8'h19, 8'h19};
        logic [2:0] fv [10] = '{3'b011, 3'b011, 3'b011, 3'b011, 3'b011, 3'b011, 3'b111, 3'b001, 3'b010, 3'b011};
        logic [31:0] d;
        logic [1:0] r;
        for (int i = 0; i < 10; i++) begin
            @(posedge mclk);
            tempCelsius <= tv[i];
            {reflectedPowerFault, supplyAboveLow, supplyBelowHigh} <= fv[i];
            settle();
            chk_pin("thermalOk", $signed(tv[i]) < 60, thermalOk);
            chk_pin("supplyOk", fv[i][1] & fv[i][0], supplyOk);
            chk_pin("healthOk", !fv[i][2] && fv[i][1] && fv[i][0] && $signed(tv[i]) < 73, healthOk);
        end
        // Every fault kind occurred above, so all sticky bits must be up
        axi_rd(`LCS_OFF_FLTLATCH, d, r);
        chk_num("fault latch", 32'hf, d);
        axi_wr(`LCS_OFF_FLTLATCH, 32'hf, r);
        axi_rd(`LCS_OFF_FLTLATCH, d, r);
        chk_num("fault latch cleared", 32'h0, d);
        axi_rd(`LCS_OFF_TEMP, d, r);
        chk_num("temp value", 32'h19, d & 32'hff);
        $display("test flags done");
    endtask : t_flags

    task automatic pwm_period(input logic [7:0] nextTemp, input int expHigh);
        int n;
        int hi;
        logic prev;
        n = 0;
        prev = 1'b1;
        while (!(prev === 1'b0 && tempPwm === 1'b1)) begin
            prev = tempPwm;
            @(negedge mclk);
            if (++n > 9000) timeout("tempPwm rise");
        end
        hi = 1;
        @(posedge mclk);
        tempCelsius <= nextTemp;
        repeat (3999) begin
            @(negedge mclk);
            if (tempPwm === 1'b1) hi++;
        end
        chk_num("pwm high cycles", 32'(expHigh), 32'(hi));
    endtask : pwm_period

    task automatic t_pwm;
        int hi;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge mclk);
        tempCelsius <= 8'h23;
        repeat (8000) @(posedge mclk);
        // Duty in effect is 35 percent, beside the raw 35 degrees
        axi_rd(`LCS_OFF_TEMP, d, r);
        chk_num("temp and duty", 32'h2323, d);
        // Mid-period change must not touch the period in progress
        pwm_period(8'h50, 35 * `LCS_PWM_TICK_CYC);
        pwm_period(8'h78, 80 * `LCS_PWM_TICK_CYC);
        pwm_period(8'hfb, 100 * `LCS_PWM_TICK_CYC);
        hi = 0;
        repeat (4000) begin
            @(negedge mclk);
            if (tempPwm === 1'b1) hi++;
        end
        chk_num("pwm below zero", 32'h0, 32'(hi));
        $display("test pwm done");
    endtask : t_pwm

    initial begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        t_regs();
        t_rf();
        t_flags();
        t_pwm();
        end_sim();
    end
endmodule : tb_top
